/* cms_consts.vh */
// constants shared by the clock master select block
`ifndef CMS_CONSTS_VH
`define CMS_CONSTS_VH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define CMS_N 4
`define CMS_IDX_W 2
`define CMS_IDX_ZERO 2'h0
`define CMS_IDX_ONE 2'h1
// ----------------------------------------------------------------
// transceiver option write that turns on the network reference clock
// ----------------------------------------------------------------
`define CMS_ADDR_OPTION_REG_8 8'h08
`define CMS_DATA_REF_CLK_EN 8'h10
// ----------------------------------------------------------------
// timing: one superframe, and the sys clock period, both in ns
// ----------------------------------------------------------------
`define CMS_SUPERFRAME_NS 32'h00B7_1B00
`define CMS_CLK_PERIOD_NS 32'h0000_0008
// missing reference: no edge seen for this many sys clocks
`define CMS_REF_TMO 8'h80
`define CMS_REF_CNT_ONE 8'h01
`define CMS_SF_CNT_ONE 32'h0000_0001
`endif

/* cms_sync2.v */
// two flip-flop synchroniser, one per bit of a vector
`timescale 1ns/1ps
module cms_sync2 #(
  parameter W = 4
) (
  input wire i_clk_sys,
  input wire i_srst,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_reg; // first stage, read only by the second
  reg [W-1:0] sync_reg; // second stage, safe for logic
  genvar g;
  // ------------------------------------------------------------
  // one synchroniser chain per bit
  // ------------------------------------------------------------
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge i_clk_sys) begin
        if (i_srst) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= i_async[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate
  assign o_sync = sync_reg;
endmodule // cms_sync2

/* cms_clock_master_select.v */
// host-side selection of the transceiver reference that clocks the shared bus
`timescale 1ns/1ps
`include "cms_consts.vh"
module cms_clock_master_select #(
  parameter SF_CYC = `CMS_SUPERFRAME_NS / `CMS_CLK_PERIOD_NS
) (
  input wire i_clk_sys,
  input wire i_srst,
  input wire [`CMS_N-1:0] i_network_ref_clock,
  input wire [`CMS_N-1:0] i_activation_irq,
  input wire [`CMS_N-1:0] i_warn_irq,
  input wire i_cfg_done,
  input wire i_sel_wr,
  input wire [`CMS_IDX_W-1:0] i_sel_idx,
  input wire i_reply_done,
  output wire o_cfg_req,
  output reg [7:0] o_cfg_addr,
  output reg [7:0] o_cfg_data,
  output reg [`CMS_N-1:0] o_control_port_enable_n,
  output reg [`CMS_IDX_W-1:0] o_clk_master_sel,
  output reg o_bus_data_clock,
  output reg o_ref_lost,
  output wire o_act_reply_req,
  output reg [`CMS_IDX_W-1:0] o_act_reply_idx,
  output reg [`CMS_N-1:0] o_activated,
  output reg o_init_done,
  output reg o_switch_overdue,
  output reg o_multichannel_mode,
  output reg o_dchan_hdlc
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_CFG = 2'b00; // issue option write to one transceiver
  localparam ST_CFG_WAIT = 2'b01; // wait for the port to finish it
  localparam ST_RUN = 2'b10; // normal operation
  localparam ST_REPLY = 2'b11; // waiting for the activate reply to go out

  // lowest set bit of a vector, used for pending and fallback picks
  function [`CMS_IDX_W-1:0] lowest;
    input [`CMS_N-1:0] v;
    integer k;
    begin
      lowest = `CMS_IDX_ZERO;
      for (k = `CMS_N - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          lowest = k[`CMS_IDX_W-1:0];
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // synchronised pins
  // ------------------------------------------------------------
  wire [`CMS_N-1:0] ref_s; // reference clocks after two flops
  wire [`CMS_N-1:0] act_s; // activation interrupt lines
  wire [`CMS_N-1:0] warn_s; // second-zero warning interrupt lines
  cms_sync2 #(.W(3 * `CMS_N)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_async({i_network_ref_clock, i_activation_irq, i_warn_irq}),
    .o_sync({ref_s, act_s, warn_s})
  );

  reg [1:0] state_reg; // sequencer state
  reg [`CMS_IDX_W-1:0] cfg_idx_reg; // transceiver being configured
  reg cfg_req_reg; // one-cycle configuration request
  reg [`CMS_N-1:0] act_d_reg; // delayed lines for edge detection
  reg [`CMS_N-1:0] warn_d_reg;
  reg [`CMS_N-1:0] act_pend_reg; // activations not yet answered
  reg master_valid_reg; // the selected reference is an active line
  reg sw_pend_reg; // a master switch is waiting for the write port
  reg [`CMS_IDX_W-1:0] sw_idx_reg; // target of that switch
  reg [31:0] sf_cnt_reg; // cycles the switch has been waiting
  reg ref_d_reg; // selected reference, one cycle late
  reg [7:0] ref_cnt_reg; // cycles since last selected edge
  reg reply_req_reg; // activate reply request level

  wire [`CMS_N-1:0] act_rise = act_s & ~act_d_reg;
  wire [`CMS_N-1:0] warn_rise = warn_s & ~warn_d_reg;
  wire run_ok = (state_reg == ST_RUN);
  // master warned this cycle, and the lines still active besides it
  // not gated by the state: a warning that lands during a reply still needs a handover
  wire master_warn = warn_rise[o_clk_master_sel];
  wire [`CMS_N-1:0] others = o_activated & ~warn_rise;
  // next activation to answer
  wire [`CMS_IDX_W-1:0] act_pick = lowest(act_pend_reg);
  // the block's own write needs the port; software writes win the cycle
  wire auto_wr_want = sw_pend_reg | (run_ok & (|act_pend_reg) & ~master_valid_reg);
  wire auto_wr = auto_wr_want & ~i_sel_wr;

  assign o_cfg_req = cfg_req_reg;
  assign o_act_reply_req = reply_req_reg;

  // ------------------------------------------------------------
  // edge detection history
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      act_d_reg <= {`CMS_N{1'b0}};
      warn_d_reg <= {`CMS_N{1'b0}};
    end else begin
      act_d_reg <= act_s;
      warn_d_reg <= warn_s;
    end
  end

  // ------------------------------------------------------------
  // init sequence over the serial control port, then run
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_reg <= ST_CFG;
      cfg_idx_reg <= `CMS_IDX_ZERO;
      cfg_req_reg <= 1'b0;
      o_cfg_addr <= 8'h00;
      o_cfg_data <= 8'h00;
      o_control_port_enable_n <= {`CMS_N{1'b1}};
      o_init_done <= 1'b0;
      o_multichannel_mode <= 1'b0;
      o_dchan_hdlc <= 1'b0;
      reply_req_reg <= 1'b0;
      o_act_reply_idx <= `CMS_IDX_ZERO;
    end else begin
      cfg_req_reg <= 1'b0;
      case (state_reg)
        ST_CFG: begin
          // select one transceiver's control port and write its option
          o_control_port_enable_n <= ~({{(`CMS_N-1){1'b0}}, 1'b1} << cfg_idx_reg);
          o_cfg_addr <= `CMS_ADDR_OPTION_REG_8;
          o_cfg_data <= `CMS_DATA_REF_CLK_EN;
          cfg_req_reg <= 1'b1;
          state_reg <= ST_CFG_WAIT;
        end
        ST_CFG_WAIT: begin
          if (i_cfg_done) begin
            o_control_port_enable_n <= {`CMS_N{1'b1}};
            if (cfg_idx_reg == `CMS_N - 1) begin
              // serial channel 3 carries the bus as multichannel, d in hdlc
              o_multichannel_mode <= 1'b1;
              o_dchan_hdlc <= 1'b1;
              o_init_done <= 1'b1;
              state_reg <= ST_RUN;
            end else begin
              cfg_idx_reg <= cfg_idx_reg + `CMS_IDX_ONE;
              state_reg <= ST_CFG;
            end
          end
        end
        ST_RUN: begin
          // answer an activation only once a master is set
          if ((|act_pend_reg) & (master_valid_reg | auto_wr)) begin
            o_act_reply_idx <= act_pick;
            reply_req_reg <= 1'b1;
            state_reg <= ST_REPLY;
          end
        end
        default: begin
          // no timeout here: data only flows after the reply goes out
          if (i_reply_done) begin
            reply_req_reg <= 1'b0;
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // activation bookkeeping and master selection
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_activated <= {`CMS_N{1'b0}};
      act_pend_reg <= {`CMS_N{1'b0}};
      o_clk_master_sel <= `CMS_IDX_ZERO;
      master_valid_reg <= 1'b0;
      sw_pend_reg <= 1'b0;
      sw_idx_reg <= `CMS_IDX_ZERO;
    end else begin
      // activation and warning from each line; a new rise wins the clear
      o_activated <= (o_activated & ~warn_rise) | act_rise;
      act_pend_reg <= (act_pend_reg & ~warn_rise &
        ~((run_ok & (master_valid_reg | auto_wr)) ?
        ({{(`CMS_N-1){1'b0}}, 1'b1} << act_pick) : {`CMS_N{1'b0}})) | act_rise;
      // the only way the select moves is a write, ours or software's
      if (i_sel_wr) begin
        o_clk_master_sel <= i_sel_idx;
        master_valid_reg <= o_activated[i_sel_idx];
      end else if (auto_wr) begin
        o_clk_master_sel <= sw_pend_reg ? sw_idx_reg : act_pick;
        master_valid_reg <= 1'b1;
      end
      // a software write to an idle line does not count as the handover
      if (auto_wr | (i_sel_wr & o_activated[i_sel_idx])) begin
        sw_pend_reg <= 1'b0;
      end
      // master about to drop: hand over to another active line
      if (master_warn & master_valid_reg) begin
        if (|(others & ~({{(`CMS_N-1){1'b0}}, 1'b1} << o_clk_master_sel))) begin
          sw_pend_reg <= 1'b1;
          sw_idx_reg <= lowest(others & ~({{(`CMS_N-1){1'b0}}, 1'b1} << o_clk_master_sel));
        end else begin
          // nothing else active: select stays, next activation takes over
          master_valid_reg <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // handover deadline: one superframe after the master's warning
  // ------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      sf_cnt_reg <= 32'h0000_0000;
      o_switch_overdue <= 1'b0;
    end else begin
      if (sw_pend_reg & ~auto_wr) begin
        sf_cnt_reg <= sf_cnt_reg + `CMS_SF_CNT_ONE;
        if (sf_cnt_reg >= SF_CYC - 1) begin
          o_switch_overdue <= 1'b1;
        end
      end else begin
        sf_cnt_reg <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // selected reference out to the bus, with a missing-clock watch
  // ------------------------------------------------------------
  // sampling a 2.048 MHz clock at 125 MHz leaves up to 8 ns of jitter;
  // the transceivers' elastic buffers absorb it
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_bus_data_clock <= 1'b0;
      ref_d_reg <= 1'b0;
      ref_cnt_reg <= 8'h00;
      o_ref_lost <= 1'b0;
    end else begin
      o_bus_data_clock <= ref_s[o_clk_master_sel];
      ref_d_reg <= ref_s[o_clk_master_sel];
      if (ref_s[o_clk_master_sel] != ref_d_reg) begin
        ref_cnt_reg <= 8'h00;
        o_ref_lost <= 1'b0;
      end else if (ref_cnt_reg == `CMS_REF_TMO) begin
        o_ref_lost <= 1'b1;
      end else begin
        ref_cnt_reg <= ref_cnt_reg + `CMS_REF_CNT_ONE;
      end
    end
  end
endmodule // cms_clock_master_select

/* cms_clock_master_select_chk.sv */
// assertion checker for the clock master select block
`timescale 1ns/1ps
`include "cms_consts.vh"
module cms_clock_master_select_chk #(
  parameter SF_CYC = 50
) (
  input wire i_clk_sys,
  input wire i_srst,
  input wire [`CMS_N-1:0] i_warn_irq,
  input wire i_sel_wr,
  input wire [`CMS_IDX_W-1:0] i_sel_idx,
  input wire i_reply_done,
  input wire o_cfg_req,
  input wire [7:0] o_cfg_addr,
  input wire [7:0] o_cfg_data,
  input wire [`CMS_N-1:0] o_control_port_enable_n,
  input wire [`CMS_IDX_W-1:0] o_clk_master_sel,
  input wire o_act_reply_req,
  input wire [`CMS_IDX_W-1:0] o_act_reply_idx,
  input wire [`CMS_N-1:0] o_activated,
  input wire o_init_done,
  input wire o_multichannel_mode,
  input wire o_dchan_hdlc
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // another activated transceiver besides the current master
  wire others = |(o_activated & ~(4'h1 << o_clk_master_sel));
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_cfg_req_pulse: assert property (o_cfg_req |=> !o_cfg_req)
    else $error("config request longer than one cycle");
  a_cfg_ref_write: assert property (o_cfg_req |-> o_cfg_addr == 8'h08 &&
    o_cfg_data == 8'h10 && $onehot(~o_control_port_enable_n))
    else $error("config write not an enable of one reference");
  a_sel_write_taken: assert property (i_sel_wr |=> o_clk_master_sel == $past(i_sel_idx))
    else $error("select write not taken");
  // the select may only move for a write, a new activation or a handover
  a_sel_change_cause: assert property ($changed(o_clk_master_sel) |->
    $past(i_sel_wr) || $rose(o_act_reply_req) || $past(o_activated, 2) != $past(o_activated))
    else $error("select moved without a cause");
  a_reply_held: assert property (o_act_reply_req && !i_reply_done |=>
    o_act_reply_req && $stable(o_act_reply_idx)) else $error("reply request dropped early");
  a_reply_activated: assert property ($rose(o_act_reply_req) |->
    o_activated[o_act_reply_idx]) else $error("reply for an inactive transceiver");
  a_warn_handover: assert property ($rose(i_warn_irq[o_clk_master_sel]) && others
    |-> ##[2:8] $changed(o_clk_master_sel)) else $error("no handover after master warning");
  a_warn_keep_sel: assert property ($rose(i_warn_irq[o_clk_master_sel]) && !others
    |=> $stable(o_clk_master_sel) [*6]) else $error("select moved with no other active");
  a_init_modes: assert property ($rose(o_init_done) |->
    o_multichannel_mode && o_dchan_hdlc) else $error("channel modes not set at init end");
  // main scenarios reached
  c_init: cover property ($rose(o_init_done));
  c_reply: cover property ($rose(o_act_reply_req));
  c_handover: cover property ($rose(i_warn_irq[o_clk_master_sel]) && others);
endmodule // cms_clock_master_select_chk

bind cms_clock_master_select cms_clock_master_select_chk #(.SF_CYC(SF_CYC)) u_chk (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_warn_irq(i_warn_irq), .i_sel_wr(i_sel_wr),
  .i_sel_idx(i_sel_idx), .i_reply_done(i_reply_done), .o_cfg_req(o_cfg_req),
  .o_cfg_addr(o_cfg_addr), .o_cfg_data(o_cfg_data),
  .o_control_port_enable_n(o_control_port_enable_n), .o_clk_master_sel(o_clk_master_sel),
  .o_act_reply_req(o_act_reply_req), .o_act_reply_idx(o_act_reply_idx),
  .o_activated(o_activated), .o_init_done(o_init_done),
  .o_multichannel_mode(o_multichannel_mode), .o_dchan_hdlc(o_dchan_hdlc));

/* cms_xcvr_model.sv */
// behavioural model of four line transceivers behind their control ports
`timescale 1ns/1ps
module cms_xcvr_model (
  input wire i_clk_sys,
  input wire i_cfg_req,
  input wire [7:0] i_cfg_addr,
  input wire [7:0] i_cfg_data,
  input wire [3:0] i_control_port_enable_n,
  output logic o_cfg_done = 1'b0,
  output logic [3:0] o_network_ref_clock = 4'h5,
  output logic [3:0] o_activation_irq = 4'h0,
  output logic [3:0] o_warn_irq = 4'h0
);
  int n_wr [4] = '{0, 0, 0, 0}; // reference enables taken, per transceiver
  int slow = 0; // alternates prompt and slow answers
  logic [3:0] ref_stop = 4'h0; // set by the bench to freeze one reference
  // all are bus slaves: nothing here drives the bus clock
  // each line runs the slot assigner on link v2, set in option_reg_6
  // no line transceivers of the other kind are fitted: their recovered clock
  // at 2.048 MHz and disabled contention are not modelled
  // references run whether locked or not, so they only stop when frozen
  always #32 o_network_ref_clock = o_network_ref_clock ^ ~ref_stop;
  // a write lands only in the transceiver whose enable is low
  always @(posedge i_clk_sys) begin
    if (i_cfg_req === 1'b1) begin
      for (int k = 0; k < 4; k++) begin
        if (!i_control_port_enable_n[k] && i_cfg_addr == 8'h08 && i_cfg_data[4]) begin
          n_wr[k]++;
        end
      end
      slow = 1 - slow;
      repeat (1 + 6 * slow) @(posedge i_clk_sys);
      #1 o_cfg_done = 1'b1;
      @(posedge i_clk_sys);
      #1 o_cfg_done = 1'b0;
    end
  end
  // reference locked to the network: interrupt level stays up
  task raise_act(input int k);
    o_activation_irq[k] = 1'b1;
  endtask
  // second zero warning bit received on this line; the line end keeps the
  // bit clear for three superframes before it deactivates
  task raise_warn(input int k);
    o_warn_irq[k] = 1'b1;
  endtask
endmodule // cms_xcvr_model

/* cms_clock_master_select_test.sv */
// self-checking bench for the clock master select block
`timescale 1ns/1ps
module cms_clock_master_select_test;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic i_sel_wr = 1'b0;
  logic [1:0] i_sel_idx = 2'h0;
  logic i_reply_done = 1'b0;
  wire o_cfg_req, o_ref_lost, o_act_reply_req, o_init_done, o_switch_overdue;
  wire o_multichannel_mode, o_dchan_hdlc, o_bus_data_clock, cfg_done;
  wire [7:0] o_cfg_addr, o_cfg_data;
  wire [3:0] o_control_port_enable_n, o_activated, ref_clk, act_irq, warn_irq;
  wire [1:0] o_clk_master_sel, o_act_reply_idx;
  int bad_count = 0;
  int checks = 0;
  logic bdc_prev; // bus clock level a half period ago
  always #4 i_clk_sys = ~i_clk_sys;
  // short superframe keeps the run brief
  cms_clock_master_select #(.SF_CYC(50)) u_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_network_ref_clock(ref_clk), .i_activation_irq(act_irq), .i_warn_irq(warn_irq),
    .i_cfg_done(cfg_done), .i_sel_wr(i_sel_wr), .i_sel_idx(i_sel_idx),
    .i_reply_done(i_reply_done), .o_cfg_req(o_cfg_req), .o_cfg_addr(o_cfg_addr),
    .o_cfg_data(o_cfg_data), .o_control_port_enable_n(o_control_port_enable_n),
    .o_clk_master_sel(o_clk_master_sel), .o_bus_data_clock(o_bus_data_clock),
    .o_ref_lost(o_ref_lost), .o_act_reply_req(o_act_reply_req),
    .o_act_reply_idx(o_act_reply_idx), .o_activated(o_activated), .o_init_done(o_init_done),
    .o_switch_overdue(o_switch_overdue), .o_multichannel_mode(o_multichannel_mode),
    .o_dchan_hdlc(o_dchan_hdlc));
  cms_xcvr_model u_xcvr (.i_clk_sys(i_clk_sys), .i_cfg_req(o_cfg_req),
    .i_cfg_addr(o_cfg_addr), .i_cfg_data(o_cfg_data),
    .i_control_port_enable_n(o_control_port_enable_n), .o_cfg_done(cfg_done),
    .o_network_ref_clock(ref_clk), .o_activation_irq(act_irq), .o_warn_irq(warn_irq));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // inputs always change 1 ns after the edge, away from sampling
  task tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // activate reply sent; request drops the cycle after it is taken
  task reply;
    i_reply_done = 1'b1;
    tick(1);
    i_reply_done = 1'b0;
    tick(2);
    chk({7'h0, o_act_reply_req}, 8'h00);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: the tests need well under 2000 cycles
  initial begin
    #200000;
    bad_count++;
    give_verdict;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    tick(16);
    i_srst = 1'b0;
    repeat (400) if (o_init_done !== 1'b1) tick(1);
    for (int k = 0; k < 4; k++) chk(8'(u_xcvr.n_wr[k]), 8'h01);
    chk({6'h0, o_multichannel_mode, o_dchan_hdlc}, 8'h03);
    // the selected reference toggles every 32 ns, four system clocks
    bdc_prev = o_bus_data_clock;
    tick(4);
    chk({7'h0, o_bus_data_clock}, {7'h0, ~bdc_prev});
    chk({7'h0, o_ref_lost}, 8'h00);
    $display("test init done");
    // first activation becomes master, reply waits as long as we like
    u_xcvr.raise_act(2);
    repeat (20) if (o_act_reply_req !== 1'b1) tick(1);
    chk({6'h0, o_clk_master_sel}, 8'h02);
    chk({6'h0, o_act_reply_idx}, 8'h02);
    tick(30);
    chk({7'h0, o_act_reply_req}, 8'h01);
    reply;
    // a later activation leaves the valid master alone
    u_xcvr.raise_act(1);
    repeat (20) if (o_act_reply_req !== 1'b1) tick(1);
    chk({6'h0, o_clk_master_sel, o_act_reply_idx}, 8'h09);
    reply;
    chk({4'h0, o_activated}, 8'h06);
    $display("test activation done");
    // back to back select writes, the last one wins
    i_sel_wr = 1'b1;
    i_sel_idx = 2'h3;
    tick(1);
    i_sel_idx = 2'h0;
    tick(1);
    chk({6'h0, o_clk_master_sel}, 8'h00);
    i_sel_idx = 2'h2;
    tick(1);
    i_sel_wr = 1'b0;
    tick(20);
    chk({6'h0, o_clk_master_sel}, 8'h02);
    $display("test select write done");
    // master warned with another active: hand over
    u_xcvr.raise_warn(2);
    tick(10);
    chk({6'h0, o_clk_master_sel}, 8'h01);
    chk({4'h0, o_activated}, 8'h02);
    // master warned with none left: keep the selection
    u_xcvr.raise_warn(1);
    tick(60);
    chk({6'h0, o_clk_master_sel}, 8'h01);
    chk({7'h0, o_switch_overdue}, 8'h00);
    $display("test deactivation done");
    // a new activation takes over the invalid master, a later one does not
    u_xcvr.raise_act(0);
    repeat (20) if (o_act_reply_req !== 1'b1) tick(1);
    chk({6'h0, o_clk_master_sel}, 8'h00);
    reply;
    u_xcvr.raise_act(3);
    repeat (20) if (o_act_reply_req !== 1'b1) tick(1);
    chk({6'h0, o_clk_master_sel, o_act_reply_idx}, 8'h03);
    reply;
    // software keeps writing an idle line: the handover waits past a superframe
    u_xcvr.raise_warn(0);
    tick(3);
    i_sel_wr = 1'b1;
    i_sel_idx = 2'h1;
    tick(60);
    chk({7'h0, o_switch_overdue}, 8'h01);
    i_sel_idx = 2'h3;
    tick(1);
    i_sel_wr = 1'b0;
    tick(2);
    chk({6'h0, o_clk_master_sel}, 8'h03);
    $display("test overdue done");
    // selected reference freezes: lost flag after the missing-clock timeout
    u_xcvr.ref_stop = 4'h8;
    tick(140);
    chk({7'h0, o_ref_lost}, 8'h01);
    $display("test reference loss done");
    give_verdict;
  end
endmodule // cms_clock_master_select_test
